// ==== bench/dmh_host_model.sv ====
// host-side master: parallel cycles and serial frames on the shared pins.
// assumes the bench resolves shared pins, pull-downs included, and feeds them back.
module dmh_host_model (
    input wire logic clk, // system clock, paces parallel cycles
    output logic ce_n, // chip enable or select a
    output logic oe_n, // read enable or clock a
    output logic we_n, // write enable or data a
    output logic [4:0] adr, // address pins
    output logic adr_en, // drives address bits 0 and 4
    output logic [7:0] dat, // data out
    output logic dat_en, // drives data and parity
    output logic par, // parity out
    input wire logic a0_in, // resolved address 0 pin
    input wire logic a4_in, // resolved address 4 pin
    input wire logic [7:0] dat_in, // resolved data pins
    input wire logic par_in // resolved parity pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {ce_n, oe_n, we_n, adr_en, dat_en, par} = 6'h38;
        {adr, dat} = 13'h0200;
    end
    // strobes held 6 clocks, data kept past the rising strobe
    task automatic par_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
            input logic bad, output logic [7:0] q, output logic qp);
        @(negedge clk);
        {adr, adr_en, dat, dat_en, par} = {a, 1'b1, d, wr, ^{a, d} ^ bad};
        {ce_n, oe_n, we_n} = {1'b0, wr, ~wr};
        repeat (6) @(negedge clk);
        {q, qp} = {dat_in, par_in};
        {ce_n, oe_n, we_n} = 3'h7;
        repeat (6) @(negedge clk);
        dat_en = 1'b0;
    endtask : par_xfer
    // select low for the frame; 48 ns clock runs only inside it
    task automatic spi_xfer(input logic chb, input logic [14:0] f, output logic [13:0] m);
        adr_en = 1'b0;
        if (chb) adr[2] = 1'b0; else oe_n = 1'b0;
        @(negedge clk);
        if (chb) adr[1] = 1'b0; else ce_n = 1'b0;
        #13;
        for (int i = 14; i >= 0; i--) begin
            if (chb) adr[3] = f[i]; else we_n = f[i];
            #24;
            if (chb) adr[2] = 1'b1; else oe_n = 1'b1;
            #24;
            if (chb) adr[2] = 1'b0; else oe_n = 1'b0;
            if (i > 0) m = {m[12:0], chb ? a4_in : a0_in};
        end
        #10;
        if (chb) adr[1] = 1'b1; else ce_n = 1'b1;
        // gap lets the core prepare the read answer
        repeat (10) @(negedge clk);
    endtask : spi_xfer
endmodule : dmh_host_model

// ==== bench/dual_mode_host_interface_tb.sv ====
// self-checking bench: parallel port and both serial channels against a register model.
// assumes the host model owns all host-side pins; pull-downs resolved here.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dual_mode_host_interface_tb import dmh_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CYC = 20;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic sa_n = 1'b1;
    logic sb_n = 1'b1;
    logic [11:0] adc = 12'h000;
    logic adc_v = 1'b0;
    logic clk_en = 1'b1;
    logic ce_n, oe_n, we_n, aen, den, hp, a0o, a0e, a4o, a4e, po, poe, doe, ack, cst, pv, fqp;
    logic [4:0] ha, pa;
    logic [7:0] hd, dd, en, th, pend, fq;
    logic [5:0] isrc;
    logic [7:0] mem [0:16];
    logic [31:0] rs = 32'h17;
    logic [31:0] r;
    int miscompares = 0, total_checks = 0, cyc = 0, n;
    wire a0 = a0e ? a0o : (aen & ha[0]);
    wire a4 = a4e ? a4o : (aen & ha[4]);
    wire [7:0] dq = doe ? dd : (den ? hd : 8'h00);
    wire pq = poe ? po : (den & hp);
    always #10 CLOCK = ~CLOCK;
    dmh_host_model host (.clk(CLOCK), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .adr(ha),
        .adr_en(aen), .dat(hd), .dat_en(den), .par(hp), .a0_in(a0), .a4_in(a4),
        .dat_in(dq), .par_in(pq));
    dmh_host_if #(.CONV_CYC(CYC)) DUT (.CLOCK(CLOCK), .RST(RST), .CLK_EN(clk_en),
        .SERIAL_A_STRAP_N(sa_n), .SERIAL_B_STRAP_N(sb_n),
        .CHIP_EN_CHAN_A_SLAVE_SELECT_N(ce_n), .OE_N_CHAN_A_SERIAL_CLOCK(oe_n),
        .WE_N_CHAN_A_MOSI(we_n), .PORT_ADDR_BIT0_I(a0), .PORT_ADDR_BIT0_O(a0o),
        .PORT_ADDR_BIT0_OE(a0e), .ADDR1_CHAN_B_SLAVE_SELECT_N(ha[1]),
        .ADDR2_CHAN_B_SERIAL_CLOCK(ha[2]), .ADDR3_CHAN_B_MOSI(ha[3]),
        .PORT_ADDR_MSB_I(a4), .PORT_ADDR_MSB_O(a4o), .PORT_ADDR_MSB_OE(a4e),
        .PORT_DATA_I(dq), .PORT_DATA_O(dd), .PORT_DATA_OE(doe), .TRANSFER_PARITY_I(pq),
        .TRANSFER_PARITY_O(po), .TRANSFER_PARITY_OE(poe), .ACK_N(ack), .ADC_SAMPLE(adc),
        .ADC_VALID(adc_v), .CONV_START(cst), .ENABLE_BITS(en), .THRESH_CODE(th),
        .ISRC_SEL(isrc));
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    function automatic logic storable(input logic [4:0] a);
        return a < 5'h11 && a != REG_ADC_LO && a != REG_ADC_HI;
    endfunction : storable
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic mirror(input logic ak);
        `CHK(ack, ak)
        `CHK(en, mem[0])
        `CHK(th, mem[3])
        `CHK(isrc, mem[4][5:0])
    endtask : mirror
    task automatic pw(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic bad);
        logic [7:0] q, e;
        logic qp;
        host.par_xfer(wr, a, d, bad, q, qp);
        e = (a < 5'h11) ? mem[a] : 8'h00;
        if (!wr) begin
            `CHK(q, e)
            `CHK(qp, ^{a, e})
        end else begin
            if (!bad && storable(a)) mem[a] = d;
            mirror(bad);
        end
    endtask : pw
    // the answer to a read frame comes out in the following frame
    task automatic sp(input logic chb, input logic rw, input logic [4:0] a, input logic [7:0] d,
            input logic bad);
        logic [13:0] m;
        host.spi_xfer(chb, {rw, a, d, ^{a, d} ^ bad}, m);
        if (pv) begin
            `CHK(m[13:9], 5'h00)
            `CHK(m[8:1], pend)
            `CHK(m[0], ^{pa, pend})
        end
        {pv, pa, pend} = {rw, a, (a < 5'h11) ? mem[a] : 8'h00};
        if (!rw && !bad && storable(a)) mem[a] = d;
        if (!rw) mirror(bad);
    endtask : sp
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        for (int i = 0; i < 17; i++) mem[i] = 8'h00;
        pv = 1'b0;
        repeat (3) @(posedge CLOCK);
        @(negedge CLOCK);
        mirror(1'b0);
        `CHK({doe, cst, a0e, a4e}, 4'h0)
        RST = 1'b0;
        repeat (4) @(negedge CLOCK);
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            pw(1'b1, r[4:0], r[12:5], r[13] & r[14]);
            pw(1'b0, r[4:0], 8'h00, 1'b0);
        end
        pw(1'b0, 5'h11, 8'h00, 1'b0);
        pw(1'b0, 5'h1f, 8'h00, 1'b0);
        $display("test parallel done");
        pw(1'b1, REG_ENABLE, 8'h01, 1'b0);
        r = rnd();
        adc = r[11:0];
        adc_v = 1'b1;
        @(negedge CLOCK);
        adc_v = 1'b0;
        mem[1] = adc[7:0];
        mem[2] = {4'h0, adc[11:8]};
        pw(1'b0, REG_ADC_LO, 8'h00, 1'b0);
        pw(1'b0, REG_ADC_HI, 8'h00, 1'b0);
        n = 0;
        while (cst !== 1'b1 && n < 100) begin
            @(negedge CLOCK);
            n++;
        end
        n = 0;
        do begin
            @(negedge CLOCK);
            n++;
        end while (cst !== 1'b1 && n < 100);
        `CHK(n, CYC)
        pw(1'b1, REG_ENABLE, 8'h00, 1'b0);
        n = 0;
        repeat (3 * CYC) begin
            @(negedge CLOCK);
            if (cst !== 1'b0) n++;
        end
        `CHK(n, 0)
        $display("test conversion done");
        // a write while the clock enable is low must leave no trace
        clk_en = 1'b0;
        host.par_xfer(1'b1, REG_THRESH, ~mem[3], 1'b0, fq, fqp);
        clk_en = 1'b1;
        mirror(1'b0);
        $display("test clock enable done");
        for (int c = 0; c < 2; c++) begin
            // one strap low at a time, changed only between frames
            {sa_n, sb_n} = c[0] ? 2'b10 : 2'b01;
            repeat (6) @(negedge CLOCK);
            pv = 1'b0;
            r = rnd();
            sp(c[0], 1'b0, c[0] ? 5'h06 : 5'h05, r[7:0], 1'b0);
            sp(c[0], 1'b0, REG_THRESH, r[15:8], 1'b1);
            sp(c[0], 1'b1, c[0] ? 5'h06 : 5'h05, r[23:16], 1'b0);
            sp(c[0], 1'b1, REG_THRESH, 8'h00, 1'b0);
            sp(c[0], 1'b1, REG_ENABLE, 8'h00, 1'b0);
            sp(c[0], 1'b0, REG_ISRC_SEL, r[31:24], 1'b0);
            $display("test serial %0d done", c);
        end
        {sa_n, sb_n} = 2'b11;
        repeat (6) @(negedge CLOCK);
        pw(1'b0, REG_ISRC_SEL, 8'h00, 1'b0);
        pw(1'b0, 5'h06, 8'h00, 1'b0);
        $display("test return to parallel done");
        tally_and_finish();
    end
endmodule : dual_mode_host_interface_tb

// ==== common/dmh_pkg.sv ====
// constants and types shared by the host interface core and its serial channel.
// assumes one system clock; serial channels run on the host's own clocks.
package dmh_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 17;
    localparam int ADC_W = 12;
    localparam int ISRC_W = 6;
    // frame: rw, address, data, parity; msb first
    localparam int FRAME_BITS = 15;
    localparam int FRM_RW = 14;
    localparam int FRM_ADDR_LSB = 9;
    localparam int FRM_DATA_LSB = 1;
    localparam logic [3:0] SPI_LAST_SLOT = 4'he;
    localparam logic [3:0] SPI_MISO_FROM = 4'h5;
    localparam logic [3:0] SPI_CNT_SAT = 4'hf;
    // synchronised control pin vector layout
    localparam int PIN_CE = 0;
    localparam int PIN_OE = 1;
    localparam int PIN_WE = 2;
    localparam int PIN_ADDR_LSB = 3;
    // register indices
    localparam logic [ADDR_W-1:0] REG_ENABLE = 5'h00;
    localparam logic [ADDR_W-1:0] REG_ADC_LO = 5'h01;
    localparam logic [ADDR_W-1:0] REG_ADC_HI = 5'h02;
    localparam logic [ADDR_W-1:0] REG_THRESH = 5'h03;
    localparam logic [ADDR_W-1:0] REG_ISRC_SEL = 5'h04;
    // enable register bits
    localparam int EN_ADC = 0;
    localparam int EN_THRESH = 1;
    localparam int EN_ISRC = 2;
    // reset values
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic ACK_RST = 1'b0;
    // conversion pacing
    localparam int CLK_HZ = 50_000_000;
    localparam int CONV_RATE_HZ = 13_000;
    localparam int CONV_CYCLES = (CLK_HZ + CONV_RATE_HZ - 1) / CONV_RATE_HZ;
    localparam int CONV_W = 12;

    typedef enum logic [2:0] {
        PAR_IDLE = 3'b001,
        PAR_READ = 3'b010,
        PAR_WRITE = 3'b100
    } dmh_par_state_t;
endpackage : dmh_pkg

// ==== core/dmh_host_if.sv ====
// dual mode host interface: strap-selected parallel port or two serial channels
// sharing pins, parity checked transfers and a 17 x 8 register bank.
// assumes pins are asynchronous to CLOCK; serial clocks come from the hosts.
// Behaviour
// - straps high: pin is parallel chip enable
// - strap A low: pin is channel A select
// - enable and select asserted when low
// - read enable, or channel A clock
// - write enable, or channel A data in
// - address bit 0, or channel A data out
// - strap B low: address 1 is select
// - address 2 is channel B clock
// - address 3 is channel B data in
// - address msb, or channel B data out
// - 8-bit data, 5-bit address, read/write
// - seventeen 8-bit registers hold all settings
// - system clock paces conversion logic
// - enable bits switch functions off
// - 12-bit samples, at most 13 kHz
// - threshold set by 8-bit code
// - current source steers to 64 inputs
// - data bits 0 to 7, msb first
// - even parity over address and data
// - parity error drives acknowledge high
// - reset returns all state to default
module dmh_host_if import dmh_pkg::*; #(
    parameter int CONV_CYC = CONV_CYCLES // system clocks per conversion
) (
    input wire logic CLOCK, // system clock
    input wire logic RST, // async reset, active high
    input wire logic CLK_EN, // freezes core state while low
    input wire logic SERIAL_A_STRAP_N, // low selects channel A
    input wire logic SERIAL_B_STRAP_N, // low selects channel B
    input wire logic CHIP_EN_CHAN_A_SLAVE_SELECT_N, // chip enable or select A
    input wire logic OE_N_CHAN_A_SERIAL_CLOCK, // read enable or clock A
    input wire logic WE_N_CHAN_A_MOSI, // write enable or data in A
    input wire logic PORT_ADDR_BIT0_I, // address bit 0 in
    output logic PORT_ADDR_BIT0_O, // channel A data out
    output logic PORT_ADDR_BIT0_OE, // drive enable, address 0 pin
    input wire logic ADDR1_CHAN_B_SLAVE_SELECT_N, // address 1 or select B
    input wire logic ADDR2_CHAN_B_SERIAL_CLOCK, // address 2 or clock B
    input wire logic ADDR3_CHAN_B_MOSI, // address 3 or data in B
    input wire logic PORT_ADDR_MSB_I, // address bit 4 in
    output logic PORT_ADDR_MSB_O, // channel B data out
    output logic PORT_ADDR_MSB_OE, // drive enable, address 4 pin
    input wire logic [DATA_W-1:0] PORT_DATA_I, // parallel data in
    output logic [DATA_W-1:0] PORT_DATA_O, // parallel read data
    output logic PORT_DATA_OE, // drive enable, data pins
    input wire logic TRANSFER_PARITY_I, // parity in
    output logic TRANSFER_PARITY_O, // parity out
    output logic TRANSFER_PARITY_OE, // drive enable, parity pin
    output logic ACK_N, // high after a parity error
    input wire logic [ADC_W-1:0] ADC_SAMPLE, // converter result
    input wire logic ADC_VALID, // one-cycle result strobe
    output logic CONV_START, // one-cycle conversion request
    output logic [DATA_W-1:0] ENABLE_BITS, // function enables
    output logic [DATA_W-1:0] THRESH_CODE, // bi-level threshold code
    output logic [ISRC_W-1:0] ISRC_SEL // current source input select
);
    localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYC - 1);

    typedef struct packed {
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic [7:0] ctl_s1;
        logic [7:0] ctl_s2;
        logic [DATA_W-1:0] dat_s1;
        logic [DATA_W-1:0] dat_s2;
        logic pty_s1;
        logic pty_s2;
        logic [1:0] tog_s1;
        logic [1:0] tog_s2;
        logic [1:0] tog_seen;
        dmh_par_state_t par_st;
        logic [ADDR_W-1:0] cap_addr;
        logic [DATA_W-1:0] cap_data;
        logic cap_pty;
        logic [ADDR_W-1:0] out_addr;
        logic [DATA_W-1:0] d_out;
        logic pty_out;
        logic d_oe;
        logic [DATA_W:0] rd_a;
        logic [DATA_W:0] rd_b;
        logic ack_n;
        logic [NUM_REGS-1:0][DATA_W-1:0] regs;
        logic [CONV_W-1:0] conv_cnt;
        logic conv_start;
    } dmh_core_t;

    dmh_core_t r, nxt;
    logic [FRAME_BITS-1:0] word_a, word_b;
    logic tog_a, tog_b, miso_a, miso_b, oe_a, oe_b;
    logic par_mode, p_ce, p_oe_n, p_we_n, par_commit, par_bad;
    logic [ADDR_W-1:0] p_addr;
    logic [1:0] tog_edge;

    function automatic logic [DATA_W-1:0] rd_reg(input dmh_core_t s,
                                                 input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        if (a < ADDR_W'(NUM_REGS)) begin
            v = s.regs[a];
        end
        return v;
    endfunction : rd_reg

    // parallel only with both straps high
    assign par_mode = r.strap_s2 == 2'b11;
    assign p_ce = ~r.ctl_s2[PIN_CE];
    assign p_oe_n = r.ctl_s2[PIN_OE];
    assign p_we_n = r.ctl_s2[PIN_WE];
    assign p_addr = r.ctl_s2[PIN_ADDR_LSB +: ADDR_W];
    assign par_commit = (r.par_st == PAR_WRITE) && !(p_ce && !p_we_n && par_mode);
    assign par_bad = ^{r.cap_addr, r.cap_data, r.cap_pty};
    assign tog_edge = r.tog_s2 ^ r.tog_seen;

    // channel A on the first four pins
    dmh_spi_slave u_chan_a (
        .sclk(OE_N_CHAN_A_SERIAL_CLOCK),
        .rst(RST),
        .ss_n(CHIP_EN_CHAN_A_SLAVE_SELECT_N),
        .mosi(WE_N_CHAN_A_MOSI),
        .chan_en(~r.strap_s2[1]),
        .rd_word(r.rd_a),
        .miso_o(miso_a),
        .miso_oe(oe_a),
        .wr_word(word_a),
        .wr_toggle(tog_a)
    );

    // channel B on the address pins
    dmh_spi_slave u_chan_b (
        .sclk(ADDR2_CHAN_B_SERIAL_CLOCK),
        .rst(RST),
        .ss_n(ADDR1_CHAN_B_SLAVE_SELECT_N),
        .mosi(ADDR3_CHAN_B_MOSI),
        .chan_en(~r.strap_s2[0]),
        .rd_word(r.rd_b),
        .miso_o(miso_b),
        .miso_oe(oe_b),
        .wr_word(word_b),
        .wr_toggle(tog_b)
    );

    always_comb begin
        logic xfer;
        logic [FRAME_BITS-1:0] xw;
        logic [1:0] sel;
        logic [ADDR_W-1:0] xa;
        logic [DATA_W-1:0] rv;
        xfer = 1'b0;
        xw = '0;
        sel = 2'b00;
        xa = '0;
        rv = '0;
        nxt = r;
        if (CLK_EN) begin
            nxt.strap_s1 = {SERIAL_A_STRAP_N, SERIAL_B_STRAP_N};
            nxt.strap_s2 = r.strap_s1;
            nxt.ctl_s1 = {PORT_ADDR_MSB_I, ADDR3_CHAN_B_MOSI, ADDR2_CHAN_B_SERIAL_CLOCK,
                          ADDR1_CHAN_B_SLAVE_SELECT_N, PORT_ADDR_BIT0_I, WE_N_CHAN_A_MOSI,
                          OE_N_CHAN_A_SERIAL_CLOCK, CHIP_EN_CHAN_A_SLAVE_SELECT_N};
            nxt.ctl_s2 = r.ctl_s1;
            nxt.dat_s1 = PORT_DATA_I;
            nxt.dat_s2 = r.dat_s1;
            nxt.pty_s1 = TRANSFER_PARITY_I;
            nxt.pty_s2 = r.pty_s1;
            nxt.tog_s1 = {tog_a, tog_b};
            nxt.tog_s2 = r.tog_s1;

            case (r.par_st)
                PAR_IDLE: begin
                    if (par_mode && p_ce && !p_oe_n) begin
                        nxt.par_st = PAR_READ;
                    end else if (par_mode && p_ce && !p_we_n) begin
                        nxt.par_st = PAR_WRITE;
                    end
                end
                PAR_READ: begin
                    if (!par_mode || !p_ce || p_oe_n) begin
                        nxt.par_st = PAR_IDLE;
                    end
                end
                PAR_WRITE: begin
                    if (par_commit) begin
                        nxt.par_st = PAR_IDLE;
                    end
                end
                default: begin
                    nxt.par_st = PAR_IDLE;
                end
            endcase
            // hold the last values seen while the write strobe is low
            if (nxt.par_st == PAR_WRITE) begin
                nxt.cap_addr = p_addr;
                nxt.cap_data = r.dat_s2;
                nxt.cap_pty = r.pty_s2;
            end

            // read data leaves with even parity
            rv = rd_reg(r, p_addr);
            nxt.d_oe = nxt.par_st == PAR_READ;
            nxt.out_addr = p_addr;
            nxt.d_out = rv;
            nxt.pty_out = ^{p_addr, rv};

            // parallel first, then channel A, then B; a waiting frame is kept
            if (par_commit) begin
                xfer = 1'b1;
                xw = {1'b0, r.cap_addr, r.cap_data, r.cap_pty};
            end else if (tog_edge[1]) begin
                xfer = 1'b1;
                xw = word_a;
                sel = 2'b10;
                nxt.tog_seen[1] = r.tog_s2[1];
            end else if (tog_edge[0]) begin
                xfer = 1'b1;
                xw = word_b;
                sel = 2'b01;
                nxt.tog_seen[0] = r.tog_s2[0];
            end
            xa = xw[FRM_ADDR_LSB +: ADDR_W];
            if (xfer) begin
                // acknowledge follows the parity of the last transfer
                // the read/write bit sits outside the parity, or every read would fail
                nxt.ack_n = ^xw[FRM_RW-1:0];
                if (!(^xw[FRM_RW-1:0])) begin
                    if (!xw[FRM_RW]) begin
                        // converter result registers are read only
                        if (xa < ADDR_W'(NUM_REGS) && xa != REG_ADC_LO && xa != REG_ADC_HI) begin
                            nxt.regs[xa] = xw[FRM_DATA_LSB +: DATA_W];
                        end
                    end else begin
                        // answer leaves in the channel's next frame
                        rv = rd_reg(r, xa);
                        if (sel[1]) begin
                            nxt.rd_a = {rv, ^{xa, rv}};
                        end
                        if (sel[0]) begin
                            nxt.rd_b = {rv, ^{xa, rv}};
                        end
                    end
                end
            end

            if (ADC_VALID && r.regs[REG_ENABLE][EN_ADC]) begin
                nxt.regs[REG_ADC_LO] = ADC_SAMPLE[DATA_W-1:0];
                nxt.regs[REG_ADC_HI] = {{(2 * DATA_W - ADC_W){1'b0}}, ADC_SAMPLE[ADC_W-1:DATA_W]};
            end
            // one conversion request every CONV_CYC clocks; a CONV_CYC below the default breaks the sample rate limit
            nxt.conv_start = 1'b0;
            if (r.regs[REG_ENABLE][EN_ADC]) begin
                if (r.conv_cnt == CONV_LAST) begin
                    nxt.conv_cnt = '0;
                    nxt.conv_start = 1'b1;
                end else begin
                    nxt.conv_cnt = r.conv_cnt + 1'b1;
                end
            end else begin
                nxt.conv_cnt = '0;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            r <= '{strap_s1: 2'b11, strap_s2: 2'b11, ctl_s1: 8'hff, ctl_s2: 8'hff,
                   par_st: PAR_IDLE, ack_n: ACK_RST, regs: {NUM_REGS{REG_RST}}, default: '0};
        end else begin
            r <= nxt;
        end
    end

    assign PORT_ADDR_BIT0_O = miso_a;
    assign PORT_ADDR_BIT0_OE = oe_a;
    assign PORT_ADDR_MSB_O = miso_b;
    assign PORT_ADDR_MSB_OE = oe_b;
    assign PORT_DATA_O = r.d_out;
    assign PORT_DATA_OE = r.d_oe;
    assign TRANSFER_PARITY_O = r.pty_out;
    assign TRANSFER_PARITY_OE = r.d_oe;
    assign ACK_N = r.ack_n;
    assign CONV_START = r.conv_start;
    assign ENABLE_BITS = r.regs[REG_ENABLE];
    assign THRESH_CODE = r.regs[REG_THRESH];
    assign ISRC_SEL = r.regs[REG_ISRC_SEL][ISRC_W-1:0];

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    chk_read_drive: assert property (r.par_st == PAR_READ |-> PORT_DATA_OE)
        else $error("parallel read without data drive");
    chk_read_parity: assert property (PORT_DATA_OE |->
        !(^{r.out_addr, PORT_DATA_O, TRANSFER_PARITY_O}))
        else $error("read parity not even");
    chk_serial_quiet: assert property (!par_mode |-> !PORT_DATA_OE)
        else $error("data pins driven in serial mode");
    chk_miso_a_mode: assert property (PORT_ADDR_BIT0_OE |-> !r.strap_s2[1])
        else $error("address 0 pin driven outside channel A mode");
    chk_miso_b_mode: assert property (PORT_ADDR_MSB_OE |-> !r.strap_s2[0])
        else $error("address 4 pin driven outside channel B mode");
    chk_ack_on_error: assert property (CLK_EN && par_commit && par_bad |=> ACK_N)
        else $error("parity error not flagged");
    chk_write_lands: assert property (CLK_EN && par_commit && !par_bad
        && r.cap_addr == REG_THRESH |=> THRESH_CODE == $past(r.cap_data))
        else $error("parallel write lost");
    chk_unmapped_zero: assert property (PORT_DATA_OE
        && r.out_addr >= ADDR_W'(NUM_REGS) |-> PORT_DATA_O == '0)
        else $error("unmapped read not zero");
    chk_conv_spacing: assert property (CONV_START |=> !CONV_START [*8])
        else $error("conversions too close");
    chk_conv_gated: assert property (!r.regs[REG_ENABLE][EN_ADC] |=> !CONV_START)
        else $error("conversion while disabled");
    chk_adc_capture: assert property (CLK_EN && ADC_VALID && ENABLE_BITS[EN_ADC]
        |=> {r.regs[REG_ADC_HI][ADC_W-DATA_W-1:0], r.regs[REG_ADC_LO]} == $past(ADC_SAMPLE))
        else $error("sample not captured");

    cov_par_read: cover property (r.par_st == PAR_READ ##1 r.par_st == PAR_IDLE);
    cov_par_write: cover property (par_commit && !par_bad);
    cov_bad_parity: cover property (par_commit && par_bad);
    cov_chan_a: cover property (CLK_EN && tog_edge[1]);
endmodule : dmh_host_if

// ==== core/dmh_spi_slave.sv ====
// one serial channel: shifts a 15-bit frame in on the host clock, answers reads
// with a word prepared by the core. assumes the core holds rd_word steady during frames.
module dmh_spi_slave import dmh_pkg::*; (
    input wire logic sclk, // serial clock from host
    input wire logic rst, // async reset, active high
    input wire logic ss_n, // slave select, active low
    input wire logic mosi, // serial data in
    input wire logic chan_en, // strap selects this channel
    input wire logic [DATA_W:0] rd_word, // read data and parity
    output logic miso_o, // serial data out
    output logic miso_oe, // drive enable for miso
    output logic [FRAME_BITS-1:0] wr_word, // last complete frame
    output logic wr_toggle // flips once per complete frame
);
    typedef struct packed {
        logic [3:0] cnt;
        logic [FRAME_BITS-2:0] sr;
        logic miso;
    } dmh_frm_t;
    typedef struct packed {
        logic [FRAME_BITS-1:0] word;
        logic tog;
    } dmh_hold_t;

    dmh_frm_t frm_r, frm_nxt;
    dmh_hold_t hold_r, hold_nxt;
    logic frame_rst;

    // the clock stops between frames, so the frame signal itself ends a frame
    assign frame_rst = ss_n | ~chan_en;

    always_comb begin
        frm_nxt = frm_r;
        hold_nxt = hold_r;
        frm_nxt.sr = {frm_r.sr[FRAME_BITS-3:0], mosi};
        if (frm_r.cnt != SPI_CNT_SAT) begin
            frm_nxt.cnt = frm_r.cnt + 4'h1;
        end
        if (frm_r.cnt == SPI_LAST_SLOT) begin
            hold_nxt.word = {frm_r.sr, mosi};
            hold_nxt.tog = ~hold_r.tog;
        end
        frm_nxt.miso = 1'b0;
        if (frm_r.cnt >= SPI_MISO_FROM && frm_r.cnt < SPI_LAST_SLOT) begin
            frm_nxt.miso = rd_word[SPI_LAST_SLOT - 4'h1 - frm_r.cnt];
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            frm_r <= '0;
        end else begin
            frm_r <= frm_nxt;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            hold_r <= '0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    assign miso_o = frm_r.miso;
    assign miso_oe = ~ss_n & chan_en;
    assign wr_word = hold_r.word;
    assign wr_toggle = hold_r.tog;

    // checked on the falling edge: no rising edge follows the last slot
    chk_frame_toggle: assert property (@(negedge sclk) disable iff (frame_rst)
        frm_r.cnt == SPI_CNT_SAT && $past(frm_r.cnt) == SPI_LAST_SLOT
        |-> wr_toggle != $past(wr_toggle))
        else $error("frame end did not flip toggle");
    chk_miso_quiet: assert property (@(posedge sclk) disable iff (frame_rst)
        frm_r.cnt <= SPI_MISO_FROM |-> !miso_o)
        else $error("miso driven high before data slots");
endmodule : dmh_spi_slave
